// file: bench/tb_esie_top.sv
/*
 * Self-checking bench for the extended interrupt block: control register,
 * extra port, edge and level requests, vectors, polling and preemption.
 * Assumes the design package and constants header are compiled first.
 */
`timescale 1ns/100ps
`include "esie_defs.svh"

// Compare, count and report one value
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tb_esie_top
    import esie_pkg::*;
;
    logic clk = 1'b0; // Core clock
    logic rst_n = 1'b0; // Async reset
    esie_sfr_req_t sfrReq = '0; // Register access
    logic [7:0] sfrRdata;
    logic sfrRdValid;
    logic sfrHit;
    logic [5:0] stdReq = 6'h00; // Standard sources
    esie_irq_out_t irqOut;
    logic vecAck = 1'b0;
    logic retiPulse = 1'b0;
    logic [7:0] svcAck;
    logic [3:0] portIn = 4'hf; // Pins idle high
    logic [3:0] portOut;
    logic [3:0] portOe;
    int n_errors = 0; // Mismatch count
    int n_checks = 0; // Comparison count

    // 50 ns period
    always #25 clk = ~clk;

    esie_top esie_top_inst (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
        .sfrRdValid(sfrRdValid), .sfrHit(sfrHit), .stdReq(stdReq), .stdEnable(6'h3f),
        .stdHighPri(6'h00), .globalEnable(1'b1), .irqOut(irqOut), .vecAck(vecAck),
        .retiPulse(retiPulse), .svcAck(svcAck), .portIn(portIn), .portOut(portOut), .portOe(portOe));

    // Advance n edges, inputs settle just after
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Byte write
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sfrReq.addr = a;
        sfrReq.wdata = d;
        sfrReq.wr = 1'b1;
        tick(1);
        sfrReq.wr = 1'b0;
    endtask : wr_byte

    // Single-bit write
    task automatic wr_bit(input logic [7:0] a, input logic v);
        tick(1);
        sfrReq.addr = a;
        sfrReq.bitVal = v;
        sfrReq.bitWr = 1'b1;
        tick(1);
        sfrReq.bitWr = 1'b0;
    endtask : wr_bit

    // Byte read, data checked one cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        sfrReq.addr = a;
        sfrReq.rd = 1'b1;
        tick(1);
        sfrReq.rd = 1'b0;
        `CHK("read valid", 1'b1, sfrRdValid)
        `CHK("read data", exp, sfrRdata)
        `CHK("address hit", a == 8'hc0 || a == 8'hd8, sfrHit)
    endtask : rd_chk

    // Wait for a request, bounded, then check source and level
    task automatic wait_req(input logic [2:0] s, input logic hi);
        int k;
        for (k = 0; k < 12 && irqOut.req !== 1'b1; k++) tick(1);
        `CHK("request", 1'b1, irqOut.req)
        `CHK("source", s, irqOut.sel)
        `CHK("vector", 8'h03 + {2'h0, s, 3'h0}, irqOut.vector)
        `CHK("level", hi, irqOut.high)
    endtask : wait_req

    // Take the vector, check service pulse
    task automatic ack(input logic [7:0] oneHot);
        vecAck = 1'b1;
        tick(1);
        vecAck = 1'b0;
        `CHK("service pulse", oneHot, svcAck)
        `CHK("request dropped", 1'b0, irqOut.req)
    endtask : ack

    // Return from service
    task automatic reti();
        retiPulse = 1'b1;
        tick(1);
        retiPulse = 1'b0;
    endtask : reti

    // Reset values, unmapped read, bit and byte access of both registers
    task automatic t_regs();
        rd_chk(8'hc0, 8'h00);
        rd_chk(8'hd8, 8'h0f);
        `CHK("port idle", 4'h0, portOe)
        `CHK("port out", 4'h0, portOut)
        wr_bit(8'hc2, 1'b1);
        rd_chk(8'hc0, 8'h04);
        wr_byte(8'hc0, 8'hc8);
        rd_chk(8'hc0, 8'hc8);
        wr_byte(8'hc0, 8'h00);
        rd_chk(8'h55, 8'h00);
        wr_byte(8'hd8, 8'h0a);
        `CHK("port byte", 4'h5, portOe)
        wr_bit(8'hd8, 1'b1);
        wr_bit(8'hd9, 1'b0);
        `CHK("port bits", 4'h6, portOe)
        // Release every pin before the outside drives them
        wr_byte(8'hd8, 8'h0f);
        portIn = 4'h6;
        tick(3);
        rd_chk(8'hd8, 8'h06);
        portIn = 4'hf;
    endtask : t_regs

    // Edge mode on the third input: flag set, vector, cleared on service
    task automatic t_edge();
        wr_byte(8'hc0, 8'h05);
        portIn[2] = 1'b0;
        tick(2);
        portIn[2] = 1'b1;
        wait_req(3'h6, 1'b0);
        rd_chk(8'hc0, 8'h07);
        ack(8'h40);
        rd_chk(8'hc0, 8'h05);
        reti();
        // Same again on the fourth input
        wr_byte(8'hc0, 8'h50);
        portIn[3] = 1'b0;
        tick(2);
        portIn[3] = 1'b1;
        wait_req(3'h7, 1'b0);
        rd_chk(8'hc0, 8'h70);
        ack(8'h80);
        rd_chk(8'hc0, 8'h50);
        reti();
    endtask : t_edge

    // Level mode on the fourth input: enable gates it, pin release drops it
    task automatic t_level();
        wr_byte(8'hc0, 8'h40);
        portIn[3] = 1'b0;
        wait_req(3'h7, 1'b0);
        wr_bit(8'hc6, 1'b0);
        tick(2);
        `CHK("disabled", 1'b0, irqOut.req)
        wr_bit(8'hc6, 1'b1);
        wait_req(3'h7, 1'b0);
        wr_bit(8'hc7, 1'b1);
        // Level output follows the new priority one edge later
        tick(1);
        wait_req(3'h7, 1'b1);
        portIn[3] = 1'b1;
        tick(4);
        `CHK("level released", 1'b0, irqOut.req)
        wr_byte(8'hc0, 8'h00);
    endtask : t_level

    // Polling, raising priority, preemption blocked while high runs
    task automatic t_prio();
        stdReq = 6'h01;
        wr_byte(8'hc0, 8'h04);
        portIn[2] = 1'b0;
        tick(3);
        wait_req(3'h0, 1'b0);
        wr_bit(8'hc3, 1'b1);
        tick(2);
        wait_req(3'h6, 1'b1);
        ack(8'h40);
        portIn[2] = 1'b1;
        tick(4);
        `CHK("low waits", 1'b0, irqOut.req)
        reti();
        wait_req(3'h0, 1'b0);
        ack(8'h01);
        stdReq = 6'h00;
        // High source preempts the running low routine
        portIn[2] = 1'b0;
        wait_req(3'h6, 1'b1);
        ack(8'h40);
        portIn[2] = 1'b1;
        tick(3);
        reti();
        tick(1);
        reti();
    endtask : t_prio

    // Reset in mid-run: control, latch and request back to idle
    task automatic t_reset();
        wr_byte(8'hd8, 8'h07);
        wr_byte(8'hc0, 8'h40);
        portIn[3] = 1'b0;
        wait_req(3'h7, 1'b0);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        `CHK("reset request", 1'b0, irqOut.req)
        `CHK("reset port", 4'h0, portOe)
        rd_chk(8'hc0, 8'h00);
        portIn[3] = 1'b1;
        tick(3);
    endtask : t_reset

    // Verdict and end of run
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_regs();
        t_edge();
        t_level();
        t_prio();
        t_reset();
        close_out();
    end

    // Hang guard, far beyond the 125 or so cycles needed
    initial begin
        #(50 * 5000);
        n_errors++;
        close_out();
    end

endmodule : tb_esie_top

// file: design/esie_defs.svh
/*
 * Constants of the extended interrupt logic: special-function addresses,
 * control register field positions, reset values and vector layout.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef ESIE_DEFS_SVH
`define ESIE_DEFS_SVH

// Special-function byte addresses
`define ESIE_CTRL_ADDR 8'hc0
`define ESIE_PORT_ADDR 8'hd8

// Bit-address groups (address bits 7..3) of the two bit-addressable registers
`define ESIE_CTRL_BITGRP 5'h18
`define ESIE_PORT_BITGRP 5'h1b

// Control register field positions, bit 7 down to bit 0
`define ESIE_IRQ3_PRI 3'h7
`define ESIE_IRQ3_EN 3'h6
`define ESIE_IRQ3_FLAG 3'h5
`define ESIE_IRQ3_EDGE 3'h4
`define ESIE_IRQ2_PRI 3'h3
`define ESIE_IRQ2_EN 3'h2
`define ESIE_IRQ2_FLAG 3'h1
`define ESIE_IRQ2_EDGE 3'h0

// Reset values
`define ESIE_CTRL_RESET 8'h00
`define ESIE_PORT_RESET 4'hf

// Port pins shared with the two extra interrupt inputs
`define ESIE_PIN_IRQ2 2'h2
`define ESIE_PIN_IRQ3 2'h3

// Vector layout: first vector, eight bytes apart
`define ESIE_VEC_BASE 8'h03
`define ESIE_SRC_IRQ2 3'h6
`define ESIE_SRC_IRQ3 3'h7

`endif

// file: design/esie_pin_sync.sv
/*
 * Two-flop synchroniser and falling-edge detector for the extra port pins.
 * Assumes pins are asynchronous to clk; the edge looks only at the second flop.
 */
`timescale 1ns/100ps

module esie_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins
    input wire logic [3:0] pinRaw,
    // Synchronised level and one-cycle falling-edge pulses
    output logic [3:0] pinSync,
    output logic [3:0] pinFall
);

    logic [3:0] stage1;  // First flop, read only by the second
    logic [3:0] pinPrev; // Previous synchronised level

    // One synchroniser per pin; idle pins read high like a pulled-up port
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_pin
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1[i] <= 1'b1;
                    pinSync[i] <= 1'b1;
                    pinPrev[i] <= 1'b1;
                end else begin
                    stage1[i] <= pinRaw[i];
                    pinSync[i] <= stage1[i];
                    pinPrev[i] <= pinSync[i];
                end
            end
            // High for one cycle after the level drops
            assign pinFall[i] = pinPrev[i] & ~pinSync[i];
        end
    endgenerate

endmodule : esie_pin_sync

// file: design/esie_pkg.sv
/*
 * Types shared by the extended interrupt logic.
 * Assumes the constants header is on the include path.
 */
`include "esie_defs.svh"

package esie_pkg;

    // One special-function access from the core, byte or single bit
    typedef struct packed {
        logic [7:0] addr;   // Byte address, or bit address when bitWr
        logic wr;           // Byte write strobe
        logic rd;           // Byte read strobe
        logic bitWr;        // Single-bit write strobe
        logic bitVal;       // Value for a single-bit write
        logic [7:0] wdata;  // Byte write data
    } esie_sfr_req_t;

    // Interrupt request presented to the core
    typedef struct packed {
        logic req;          // A source is granted and waiting for the core
        logic [2:0] sel;    // Index of the granted source, 0 highest
        logic high;         // Granted source sits in the high level
        logic [7:0] vector; // Fixed vector address of the source
    } esie_irq_out_t;

endpackage : esie_pkg

// file: design/esie_top.sv
/*
 * Eight-source two-level interrupt selection with two extra external inputs,
 * their control register, and the 4-bit bit-addressable extra port.
 * Assumes the core supplies the six standard requests with their enables and
 * priorities, pulses vecAck when it takes a vector and retiPulse on return.
 */
`timescale 1ns/100ps
`include "esie_defs.svh"

module esie_top
    import esie_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Special-function access from the core
    input esie_sfr_req_t sfrReq,
    output logic [7:0] sfrRdata,
    output logic sfrRdValid,
    output logic sfrHit,
    // Standard sources and their settings from the core
    input wire logic [5:0] stdReq,
    input wire logic [5:0] stdEnable,
    input wire logic [5:0] stdHighPri,
    input wire logic globalEnable,
    // Vector handshake with the core
    output esie_irq_out_t irqOut,
    input wire logic vecAck,
    input wire logic retiPulse,
    output logic [7:0] svcAck,
    // Extra port pins
    input wire logic [3:0] portIn,
    output logic [3:0] portOut,
    output logic [3:0] portOe
);

    logic [7:0] ctrl;        // Extended interrupt control register
    logic [3:0] portLatch;   // Port output latch
    logic [3:0] pinSync;     // Synchronised pin levels
    logic [3:0] pinFall;     // Falling-edge pulses
    logic inSvcHigh;         // High-level routine running
    logic inSvcLow;          // Low-level routine running
    logic [7:0] next_ctrl;
    logic [3:0] next_portLatch;

    // Pins pass two flops before any logic looks at them
    esie_pin_sync esie_pin_sync_inst (
        .clk(clk),
        .rst_n(rst_n),
        .pinRaw(portIn),
        .pinSync(pinSync),
        .pinFall(pinFall)
    );

    // Address and bit decode
    wire ctrlByteHit = sfrReq.addr == `ESIE_CTRL_ADDR;
    wire portByteHit = sfrReq.addr == `ESIE_PORT_ADDR;
    wire ctrlBitHit = sfrReq.bitWr && sfrReq.addr[7:3] == `ESIE_CTRL_BITGRP;
    wire portBitHit = sfrReq.bitWr && sfrReq.addr[7:3] == `ESIE_PORT_BITGRP && !sfrReq.addr[2];
    wire [2:0] bitIdx = sfrReq.addr[2:0];

    // Pins 3 and 2 are the extra interrupt inputs
    wire pin2 = pinSync[`ESIE_PIN_IRQ2];
    wire pin3 = pinSync[`ESIE_PIN_IRQ3];
    wire fall2 = pinFall[`ESIE_PIN_IRQ2];
    wire fall3 = pinFall[`ESIE_PIN_IRQ3];
    wire edge2 = ctrl[`ESIE_IRQ2_EDGE];
    wire edge3 = ctrl[`ESIE_IRQ3_EDGE];

    // Hardware flag events; edge mode only
    wire set2 = edge2 && fall2;
    wire set3 = edge3 && fall3;
    wire svc2 = vecAck && irqOut.req && irqOut.sel == `ESIE_SRC_IRQ2 && edge2;
    wire svc3 = vecAck && irqOut.req && irqOut.sel == `ESIE_SRC_IRQ3 && edge3;

    // Raw requests: edge mode uses the flag, level mode the live pin
    wire raw2 = edge2 ? ctrl[`ESIE_IRQ2_FLAG] : !pin2;
    wire raw3 = edge3 ? ctrl[`ESIE_IRQ3_FLAG] : !pin3;

    // Enabled requests in vector order, index 0 highest
    wire [7:0] reqVec = {raw3 && ctrl[`ESIE_IRQ3_EN],
                         raw2 && ctrl[`ESIE_IRQ2_EN],
                         stdReq & stdEnable} & {8{globalEnable}};
    wire [7:0] priVec = {ctrl[`ESIE_IRQ3_PRI], ctrl[`ESIE_IRQ2_PRI], stdHighPri};
    wire [7:0] reqHigh = reqVec & priVec;
    wire [7:0] reqLow = reqVec & ~priVec;

    // Lowest set index wins within a level
    function automatic logic [2:0] esie_first(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                idx = 3'(k);
            end
        end
        return idx;
    endfunction : esie_first

    // Grant: high preempts low, nothing preempts its own level
    wire grantHigh = |reqHigh && !inSvcHigh;
    wire grantLow = |reqLow && !inSvcHigh && !inSvcLow;
    wire next_req = (grantHigh || grantLow) && !vecAck;
    wire [2:0] next_sel = grantHigh ? esie_first(reqHigh) : esie_first(reqLow);
    wire [7:0] next_vector = `ESIE_VEC_BASE + {2'h0, next_sel, 3'h0};

    // Control register: software first, service clear, edge set wins
    always_comb begin
        next_ctrl = ctrl;
        if (sfrReq.wr && ctrlByteHit) begin
            next_ctrl = sfrReq.wdata;
        end
        if (ctrlBitHit) begin
            next_ctrl[bitIdx] = sfrReq.bitVal;
        end
        if (svc2) begin
            next_ctrl[`ESIE_IRQ2_FLAG] = 1'b0;
        end
        if (svc3) begin
            next_ctrl[`ESIE_IRQ3_FLAG] = 1'b0;
        end
        if (set2) begin
            next_ctrl[`ESIE_IRQ2_FLAG] = 1'b1;
        end
        if (set3) begin
            next_ctrl[`ESIE_IRQ3_FLAG] = 1'b1;
        end
    end

    // Port latch: byte write or single-bit set and clear
    always_comb begin
        next_portLatch = portLatch;
        if (sfrReq.wr && portByteHit) begin
            next_portLatch = sfrReq.wdata[3:0];
        end
        if (portBitHit) begin
            next_portLatch[bitIdx[1:0]] = sfrReq.bitVal;
        end
    end

    // Register state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `ESIE_CTRL_RESET;
            portLatch <= `ESIE_PORT_RESET;
        end else begin
            ctrl <= next_ctrl;
            portLatch <= next_portLatch;
        end
    end

    // Quasi-bidirectional drive: pull low on a 0, release on a 1
    assign portOut = 4'h0;
    assign portOe = ~portLatch;

    // Read data; port reads pin levels, upper bits zero
    wire [7:0] readMux = ctrlByteHit ? ctrl : portByteHit ? {4'h0, pinSync} : 8'h00;
    assign sfrHit = ctrlByteHit || portByteHit;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfrRdata <= 8'h00;
            sfrRdValid <= 1'b0;
        end else begin
            sfrRdValid <= sfrReq.rd;
            if (sfrReq.rd) begin
                sfrRdata <= readMux;
            end
        end
    end

    // Granted request, held in flops for the core
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqOut <= '0;
        end else begin
            irqOut.req <= next_req;
            irqOut.sel <= next_sel;
            irqOut.high <= grantHigh;
            irqOut.vector <= next_vector;
        end
    end

    // Service tracking and acknowledge pulse to the source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inSvcHigh <= 1'b0;
            inSvcLow <= 1'b0;
            svcAck <= 8'h00;
        end else begin
            svcAck <= (vecAck && irqOut.req) ? (8'h01 << irqOut.sel) : 8'h00;
            if (vecAck && irqOut.req) begin
                if (irqOut.high) begin
                    inSvcHigh <= 1'b1;
                end else begin
                    inSvcLow <= 1'b1;
                end
            end else if (retiPulse) begin
                if (inSvcHigh) begin
                    inSvcHigh <= 1'b0;
                end else begin
                    inSvcLow <= 1'b0;
                end
            end
        end
    end

    // Checks
    wire [7:0] belowSel = (8'h01 << irqOut.sel) - 8'h01;

    sequence s_fall3;
        edge3 ##0 fall3;
    endsequence

    sequence s_fall2;
        edge2 ##0 fall2;
    endsequence

    property p_flag3Set;
        @(posedge clk) disable iff (!rst_n) s_fall3 |=> ctrl[`ESIE_IRQ3_FLAG];
    endproperty
    a_flag3Set: assert property (p_flag3Set) else $error("irq3 edge did not set flag");

    property p_flag2Set;
        @(posedge clk) disable iff (!rst_n) s_fall2 |=> ctrl[`ESIE_IRQ2_FLAG];
    endproperty
    a_flag2Set: assert property (p_flag2Set) else $error("irq2 edge did not set flag");

    property p_flag3Clr;
        @(posedge clk) disable iff (!rst_n) svc3 && !fall3 && !ctrlBitHit && !sfrReq.wr |=> !ctrl[`ESIE_IRQ3_FLAG];
    endproperty
    a_flag3Clr: assert property (p_flag3Clr) else $error("irq3 flag not cleared on service");

    property p_level3;
        @(posedge clk) disable iff (!rst_n) !edge3 && ctrl[`ESIE_IRQ3_EN] && globalEnable |-> reqVec[7] == !pin3;
    endproperty
    a_level3: assert property (p_level3) else $error("irq3 level request wrong");

    property p_level2;
        @(posedge clk) disable iff (!rst_n) !edge2 && ctrl[`ESIE_IRQ2_EN] && globalEnable |-> reqVec[6] == !pin2;
    endproperty
    a_level2: assert property (p_level2) else $error("irq2 level request wrong");

    property p_en3;
        @(posedge clk) disable iff (!rst_n) !ctrl[`ESIE_IRQ3_EN] |-> !reqVec[7];
    endproperty
    a_en3: assert property (p_en3) else $error("irq3 requested while disabled");

    property p_en2;
        @(posedge clk) disable iff (!rst_n) !ctrl[`ESIE_IRQ2_EN] |-> !reqVec[6];
    endproperty
    a_en2: assert property (p_en2) else $error("irq2 requested while disabled");

    property p_vector;
        @(posedge clk) disable iff (!rst_n) irqOut.req |-> irqOut.vector == {2'h0, irqOut.sel, 3'h3};
    endproperty
    a_vector: assert property (p_vector) else $error("vector address wrong");

    property p_poll;
        @(posedge clk) disable iff (!rst_n)
            irqOut.req && irqOut.high |-> ($past(reqHigh) & belowSel) == 8'h00;
    endproperty
    a_poll: assert property (p_poll) else $error("higher polled source skipped");

    property p_preempt;
        @(posedge clk) disable iff (!rst_n)
            irqOut.req |-> !$past(inSvcHigh) && (irqOut.high || !$past(inSvcLow));
    endproperty
    a_preempt: assert property (p_preempt) else $error("grant ignored running level");

    property p_portBit;
        @(posedge clk) disable iff (!rst_n) portBitHit && !sfrReq.wr |=> portOe[$past(bitIdx[1:0])] == !$past(sfrReq.bitVal);
    endproperty
    a_portBit: assert property (p_portBit) else $error("port bit op not applied");

    property p_ctrlBit;
        @(posedge clk) disable iff (!rst_n) ctrlBitHit && bitIdx == `ESIE_IRQ2_EN && !sfrReq.wr |=> ctrl[`ESIE_IRQ2_EN] == $past(sfrReq.bitVal);
    endproperty
    a_ctrlBit: assert property (p_ctrlBit) else $error("control bit op not applied");

endmodule : esie_top
